//--- hw/vmta_top.sv
// Chosen here: register access over Wishbone and the placing of the registers.
`include "vmta_map.svh"
module vmta_top (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Host I/O channel
	input wire logic HOST_SEL,
	input wire logic HOST_WR,
	input wire logic [16:0] HOST_ADDR,
	input wire logic [7:0] HOST_WDATA,
	output logic [7:0] HOST_RDATA,
	output logic HOST_RDY,
	output logic GFX_MEM_SELECT_N,
	// Raster controller
	input wire logic [13:1] DISP_ADDR,
	input wire logic [3:0] ROW_ADDR,
	input wire logic VSYNC,
	output logic WORD_HALF_SELECT,
	output logic CHAR_CLK,
	output logic DOT_CLK,
	// Dynamic RAM
	output logic RAS_N,
	output logic CAS_N,
	output logic ROW_COL_SELECT,
	output logic DISPLAY_CPU_SLOT,
	output logic [7:0] RAM_ADDR,
	output logic BANK_SELECT_0,
	output logic BANK_SELECT_1,
	output logic GFX_WRITE_ENABLE_N,
	output logic [1:0] LANE_WE_N,
	input wire logic [15:0] RAM_DQ_IN,
	output logic [15:0] RAM_DQ_OUT,
	output logic RAM_DQ_OE_N,
	output logic [1:0] READ_LANE_ENABLE_N,
	// Word latches and character path
	output logic FIRST_WORD_STROBE,
	output logic SECOND_WORD_STROBE,
	output logic [7:0] CHAR_CODE,
	output logic [7:0] ATTR_BITS,
	input wire logic FONT_DOUBLE,
	output logic [12:0] CGEN_ADDR,
	output logic CGEN_EN_N,
	input wire logic [7:0] CGEN_DATA,
	output logic SHIFT_LOAD_N,
	input wire logic UNDERLINE_IN,
	output logic [1:0] VIDEO_BITS,
	// Blink
	output logic CHAR_BLINK,
	output logic CURSOR_BLINK
);
	// Phase decode for the row and column strobes, one function each
	function automatic logic in_ras(input vmta_pkg::vmta_phase_t p);
		in_ras = (p != vmta_pkg::PH6) && (p != vmta_pkg::PH7);
	endfunction : in_ras

	function automatic logic in_cas(input vmta_pkg::vmta_phase_t p);
		in_cas = (p == vmta_pkg::PH1) || (p == vmta_pkg::PH2) ||
			(p == vmta_pkg::PH4) || (p == vmta_pkg::PH5);
	endfunction : in_cas

	vmta_pkg::vmta_ctrl_t ctrl;
	vmta_pkg::vmta_phase_t phase;
	vmta_pkg::vmta_phase_t next_phase;
	vmta_pkg::vmta_host_t hreq;
	logic div_tog;
	logic disp_slot;
	logic host_act;
	logic host_done;
	logic [15:0] w1;
	logic [15:0] w2;
	logic [15:0] rd_word;
	logic [15:0] shreg;
	logic [4:0] blink_cnt;
	logic char_ph;
	logic cur_ph;
	logic vsync_d;

	// Base clock enable: every clock in hi res, every other one otherwise
	wire base_en = ctrl.hi_res_enable | div_tog;
	wire char_end = base_en && (phase == vmta_pkg::PH7);
	wire cap1 = base_en && (phase == vmta_pkg::PH2);
	wire cap2 = base_en && (phase == vmta_pkg::PH5);
	wire half = (phase == vmta_pkg::PH3) || (phase == vmta_pkg::PH4) ||
		(phase == vmta_pkg::PH5) || (phase == vmta_pkg::PH6) ||
		(phase == vmta_pkg::PH7);
	wire l400 = ctrl.four_hundred_line & ctrl.hi_res_enable;
	wire gfx400 = ctrl.graphics_mode & ctrl.four_hundred_gfx_line;
	wire gfx200 = ctrl.graphics_mode & ~ctrl.four_hundred_gfx_line;

	// Display word address; row lines join the address in graphics
	wire [13:0] disp_word = gfx400 ? {ROW_ADDR[1:0], DISP_ADDR[11:1], half} :
		gfx200 ? {ROW_ADDR[1], DISP_ADDR[12:1], half} :
		{DISP_ADDR[13:1], half};
	wire [13:0] act_word = disp_slot ? disp_word : hreq.word;
	// Column is the low six bits, row the high eight
	wire [7:0] row_bits = act_word[13:6];
	wire [7:0] col_bits = {2'b00, act_word[5:0]};
	wire host_wr_now = host_act & hreq.wr;
	wire we_win = (phase == vmta_pkg::PH1) || (phase == vmta_pkg::PH2);
	wire [15:0] cur_word = disp_slot ? w1 : w2;

	// Johnson chain step: shift in the inverse of the last bit
	assign next_phase = vmta_pkg::vmta_phase_t'({phase[2:0], ~phase[3]});

	// Wishbone decode
	wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire hit_ctrl = WB_ADR_I == `VMTA_CTRL_OFS;
	wire hit_stat = WB_ADR_I == `VMTA_STAT_OFS;
	wire ctrl_wr = wb_req & WB_WE_I & hit_ctrl & WB_SEL_I[0];
	wire [31:0] stat_word = {24'h0000_00, phase, CURSOR_BLINK, CHAR_BLINK, host_act, disp_slot};
	wire [31:0] rd_mux = hit_ctrl ? {27'h000_0000, ctrl} : hit_stat ? stat_word : 32'h0000_0000;

	// Bus slave: one wait cycle, unmapped reads give zero
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
			ctrl <= `VMTA_CTRL_RST;
		end
		else
		begin
			WB_ACK_O <= wb_req;
			if (wb_req)
				WB_DAT_O <= rd_mux;
			if (ctrl_wr)
				ctrl <= WB_DAT_I[4:0];
		end
	end

	// Divide-by-two flop and four-flop timing chain
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			div_tog <= 1'b0;
			phase <= vmta_pkg::PH0;
		end
		else
		begin
			div_tog <= ~div_tog;
			if (base_en)
				phase <= next_phase;
		end
	end

	// Slot arbitration: raster and host take turns
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			disp_slot <= 1'b1;
			host_act <= 1'b0;
			host_done <= 1'b0;
			hreq <= '0;
		end
		else
		begin
			if (char_end)
				disp_slot <= ~disp_slot;
			// Request is frozen at slot start so the bus can change later
			if (char_end && disp_slot && HOST_SEL && !host_done)
			begin
				host_act <= 1'b1;
				hreq <= {HOST_WR, HOST_ADDR[16:15], HOST_ADDR[14:1], HOST_ADDR[0], HOST_WDATA};
			end
			else if (char_end)
				host_act <= 1'b0;
			// Done stays set until the host drops its select
			if (char_end && host_act)
				host_done <= 1'b1;
			else if (!HOST_SEL)
				host_done <= 1'b0;
		end
	end

	// Host handshake pins
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			GFX_MEM_SELECT_N <= 1'b1;
			HOST_RDY <= 1'b1;
		end
		else
		begin
			GFX_MEM_SELECT_N <= ~HOST_SEL;
			HOST_RDY <= ~HOST_SEL | host_done | (char_end & host_act);
		end
	end

	// RAM strobes and address multiplexer, all registered
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			RAS_N <= 1'b1;
			CAS_N <= 1'b1;
			ROW_COL_SELECT <= 1'b0;
			DISPLAY_CPU_SLOT <= 1'b1;
			WORD_HALF_SELECT <= 1'b0;
			RAM_ADDR <= 8'h00;
			BANK_SELECT_0 <= 1'b0;
			BANK_SELECT_1 <= 1'b0;
		end
		else
		begin
			RAS_N <= ~in_ras(phase);
			CAS_N <= ~in_cas(phase);
			ROW_COL_SELECT <= phase != vmta_pkg::PH0;
			DISPLAY_CPU_SLOT <= disp_slot;
			WORD_HALF_SELECT <= half;
			RAM_ADDR <= (phase == vmta_pkg::PH0) ? row_bits : col_bits;
			// Display reads the one bank with both selects high; host picks one of four
			BANK_SELECT_0 <= disp_slot | ~hreq.bank[0];
			BANK_SELECT_1 <= disp_slot | hreq.bank[1];
		end
	end

	// Write path: byte on both lanes, only one lane strobed
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			GFX_WRITE_ENABLE_N <= 1'b1;
			LANE_WE_N <= 2'b11;
			RAM_DQ_OUT <= 16'h0000;
			RAM_DQ_OE_N <= 1'b1;
		end
		else
		begin
			GFX_WRITE_ENABLE_N <= ~(host_wr_now & we_win);
			LANE_WE_N[0] <= ~(host_wr_now & we_win & ~hreq.lane);
			LANE_WE_N[1] <= ~(host_wr_now & we_win & hreq.lane);
			RAM_DQ_OUT <= {hreq.data, hreq.data};
			RAM_DQ_OE_N <= ~host_wr_now;
		end
	end

	// Read capture: full word latched, then one byte to the host
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rd_word <= 16'h0000;
			HOST_RDATA <= 8'h00;
			READ_LANE_ENABLE_N <= 2'b11;
		end
		else
		begin
			if (cap1 && host_act && !hreq.wr)
				rd_word <= RAM_DQ_IN;
			if (char_end && host_act && !hreq.wr)
			begin
				HOST_RDATA <= hreq.lane ? rd_word[15:8] : rd_word[7:0];
				READ_LANE_ENABLE_N <= {~hreq.lane, hreq.lane};
			end
			else if (!HOST_SEL)
				READ_LANE_ENABLE_N <= 2'b11;
		end
	end

	// Display word latches on the two CAS windows
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			w1 <= 16'h0000;
			w2 <= 16'h0000;
			FIRST_WORD_STROBE <= 1'b0;
			SECOND_WORD_STROBE <= 1'b0;
		end
		else
		begin
			FIRST_WORD_STROBE <= cap1 & disp_slot;
			SECOND_WORD_STROBE <= cap2 & disp_slot;
			if (cap1 && disp_slot)
				w1 <= RAM_DQ_IN;
			if (cap2 && disp_slot)
				w2 <= RAM_DQ_IN;
		end
	end

	// Font lookup two phases ahead of the load, fed by the current word
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			CGEN_ADDR <= 13'h0000;
			CGEN_EN_N <= 1'b1;
			CHAR_CODE <= 8'h00;
			ATTR_BITS <= 8'h00;
		end
		else
		begin
			CGEN_EN_N <= ctrl.graphics_mode;
			if (cap2)
			begin
				CHAR_CODE <= cur_word[7:0];
				ATTR_BITS <= cur_word[15:8];
				CGEN_ADDR <= {FONT_DOUBLE, cur_word[7:0], ROW_ADDR};
			end
		end
	end

	// Dot shifter: one bit per dot in text, two pixel bits in graphics
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			shreg <= 16'h0000;
			SHIFT_LOAD_N <= 1'b1;
			VIDEO_BITS <= 2'b00;
		end
		else
		begin
			SHIFT_LOAD_N <= ~char_end;
			if (char_end)
				shreg <= ctrl.graphics_mode ? cur_word : {CGEN_DATA, 8'h00};
			else if (base_en)
				shreg <= ctrl.graphics_mode ? {shreg[13:0], 2'b00} : {shreg[14:0], 1'b0};
			if (base_en)
				VIDEO_BITS <= ctrl.graphics_mode ? shreg[15:14] : {1'b0, shreg[15] | UNDERLINE_IN};
		end
	end

	// Clock enable pulses to the raster side
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			DOT_CLK <= 1'b0;
			CHAR_CLK <= 1'b0;
		end
		else
		begin
			DOT_CLK <= base_en;
			CHAR_CLK <= char_end;
		end
	end

	// Blink divider counted in frames on the vsync rising edge
	wire vs_rise = VSYNC & ~vsync_d;
	wire cur_wrap = (blink_cnt == 5'(`VMTA_CUR_TOG - 1)) || (blink_cnt == 5'(`VMTA_CHAR_TOG - 1));
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			vsync_d <= 1'b0;
			blink_cnt <= 5'h00;
			char_ph <= 1'b0;
			cur_ph <= 1'b0;
			CHAR_BLINK <= 1'b0;
			CURSOR_BLINK <= 1'b0;
		end
		else
		begin
			vsync_d <= VSYNC;
			if (vs_rise)
			begin
				blink_cnt <= (blink_cnt == 5'(`VMTA_CHAR_TOG - 1)) ? 5'h00 : blink_cnt + 5'h01;
				if (blink_cnt == 5'(`VMTA_CHAR_TOG - 1))
					char_ph <= ~char_ph;
				if (cur_wrap)
					cur_ph <= ~cur_ph;
			end
			CHAR_BLINK <= char_ph & ctrl.blink_allow;
			CURSOR_BLINK <= cur_ph;
		end
	end
endmodule : vmta_top

//--- inc/vmta_map.svh
`ifndef VMTA_MAP_SVH
`define VMTA_MAP_SVH
// Register byte offsets on the Wishbone slave
`define VMTA_CTRL_OFS 4'h0
`define VMTA_STAT_OFS 4'h4
`define VMTA_CTRL_RST 5'h00
// Control register field positions
`define VMTA_CTRL_HIRES 0
`define VMTA_CTRL_GFX 1
`define VMTA_CTRL_BLINK 2
`define VMTA_CTRL_L400 3
`define VMTA_CTRL_GL400 4
// Timing figures and derived counts
`define VMTA_CLK_NS 50
`define VMTA_DOT_NS 50
`define VMTA_CHAR_NS 400
`define VMTA_DOT_CYC ((`VMTA_DOT_NS + `VMTA_CLK_NS - 1) / `VMTA_CLK_NS)
`define VMTA_DOTS_PER_CHAR (`VMTA_CHAR_NS / `VMTA_DOT_NS)
`define VMTA_VSYNC_HZ 60
`define VMTA_CHAR_BLINK_HZ 1
`define VMTA_CUR_BLINK_HZ 2
`define VMTA_CHAR_TOG (`VMTA_VSYNC_HZ / (2 * `VMTA_CHAR_BLINK_HZ))
`define VMTA_CUR_TOG (`VMTA_VSYNC_HZ / (2 * `VMTA_CUR_BLINK_HZ))
`endif

//--- inc/vmta_pkg.sv
package vmta_pkg;
	// Johnson phases of the four-flop chain: one bit changes per step
	typedef enum logic [3:0] {
		PH0 = 4'b0000,
		PH1 = 4'b0001,
		PH2 = 4'b0011,
		PH3 = 4'b0111,
		PH4 = 4'b1111,
		PH5 = 4'b1110,
		PH6 = 4'b1100,
		PH7 = 4'b1000
	} vmta_phase_t;
	// Mode bits as software writes them
	typedef struct packed {
		logic four_hundred_gfx_line;
		logic four_hundred_line;
		logic blink_allow;
		logic graphics_mode;
		logic hi_res_enable;
	} vmta_ctrl_t;
	// Host request captured at slot start
	typedef struct packed {
		logic wr;
		logic [1:0] bank;
		logic [13:0] word;
		logic lane;
		logic [7:0] data;
	} vmta_host_t;
endpackage : vmta_pkg

//--- test/test_video_memory_timing_arbiter.sv
module test_video_memory_timing_arbiter;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK = 1'b0, RESET_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
	logic HOST_SEL = 1'b0, HOST_WR = 1'b0, VSYNC = 1'b0, FONT_DOUBLE = 1'b0, UNDERLINE_IN = 1'b0;
	logic [3:0] WB_ADR_I = 4'h0, WB_SEL_I = 4'h0, ROW_ADDR = 4'h0;
	logic [31:0] WB_DAT_I = 32'h0000_0000, WB_DAT_O;
	logic [16:0] HOST_ADDR = 17'h0_0000;
	logic [7:0] HOST_WDATA = 8'h00, CGEN_DATA = 8'h00, HOST_RDATA, CHAR_CODE, ATTR_BITS, RAM_ADDR;
	logic [12:0] DISP_ADDR = 13'h0000, CGEN_ADDR;
	logic [15:0] RAM_DQ_IN, RAM_DQ_OUT;
	logic [1:0] LANE_WE_N, READ_LANE_ENABLE_N, VIDEO_BITS;
	logic WB_ACK_O, HOST_RDY, GFX_MEM_SELECT_N, WORD_HALF_SELECT, CHAR_CLK, DOT_CLK, RAS_N, CAS_N;
	logic ROW_COL_SELECT, DISPLAY_CPU_SLOT, BANK_SELECT_0, BANK_SELECT_1, GFX_WRITE_ENABLE_N, RAM_DQ_OE_N;
	logic FIRST_WORD_STROBE, SECOND_WORD_STROBE, CGEN_EN_N, SHIFT_LOAD_N, CHAR_BLINK, CURSOR_BLINK;
	logic rdy_q = 1'b1;
	int failures = 0, n_checks = 0;
	logic [31:0] wbq [$];
	logic [9:0] hq [$];
	vmta_top i_dut (.*);
	vmta_dram_model i_ram (.*);
	always #25 CLOCK = ~CLOCK;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// Bounded wait; a hang ends the run as a failure
	task automatic wait_level(ref logic s, input logic v);
		int n;
		for (n = 0; n < 200 && s !== v; n++)
			@(posedge CLOCK);
		if (n == 200)
		begin
			failures++;
			finish_test;
		end
	endtask : wait_level
	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] d,
		input logic [31:0] exp);
		@(posedge CLOCK);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= adr;
		WB_SEL_I <= sel;
		WB_DAT_I <= d;
		if (!we)
			wbq.push_back(exp);
		wait_level(WB_ACK_O, 1'b1);
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge CLOCK);
	endtask : wb
	task automatic host(input logic wr, input logic [16:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge CLOCK);
		HOST_SEL <= 1'b1;
		HOST_WR <= wr;
		HOST_ADDR <= a;
		HOST_WDATA <= d;
		if (!wr)
			hq.push_back({~a[0], a[0], exp});
		repeat (2) @(posedge CLOCK);
		wait_level(HOST_RDY, 1'b1);
		HOST_SEL <= 1'b0;
		@(posedge CLOCK);
	endtask : host
	task automatic char_period(input int exp);
		int n;
		int dots;
		wait_level(CHAR_CLK, 1'b1);
		@(posedge CLOCK);
		dots = 32'(DOT_CLK);
		for (n = 1; n < 40 && CHAR_CLK !== 1'b1; n++)
		begin
			@(posedge CLOCK);
			dots += 32'(DOT_CLK);
		end
		check(32'(n), 32'(exp));
		check(32'(dots), 32'h0000_0008);
	endtask : char_period
	// Raster side inputs wander at random; word addressing keeps line bytes even
	always @(posedge CLOCK)
	begin
		DISP_ADDR <= 13'($urandom);
		ROW_ADDR <= 4'($urandom);
		CGEN_DATA <= 8'($urandom);
		UNDERLINE_IN <= 1'($urandom);
	end
	// Results taken off the queues as they appear
	always @(posedge CLOCK)
	begin
		if (WB_ACK_O && !WB_WE_I)
			check(WB_DAT_O, wbq.pop_front());
		if (HOST_SEL && !HOST_WR && HOST_RDY && !rdy_q)
			check(32'({READ_LANE_ENABLE_N, HOST_RDATA}), 32'(hq.pop_front()));
		rdy_q <= HOST_RDY;
	end
	initial
	begin
		logic [16:0] a;
		logic [7:0] d;
		logic [4:0] c;
		void'($urandom(48));
		FONT_DOUBLE = 1'($urandom);
		repeat (8) @(posedge CLOCK);
		check(32'({RAS_N, CAS_N, HOST_RDY, GFX_MEM_SELECT_N}), 32'h0000_000F);
		RESET_N <= 1'b1;
		wb(1'b0, 4'h0, 4'hF, '0, 32'h0000_0000);
		wb(1'b0, 4'h8, 4'hF, '0, 32'h0000_0000);
		c = 5'($urandom);
		wb(1'b1, 4'h0, 4'hF, 32'(c), '0);
		wb(1'b1, 4'h0, 4'h2, 32'h0000_001F, '0);
		wb(1'b0, 4'h0, 4'hF, '0, 32'(c));
		// Low then high resolution, byte pairs on both lanes
		for (int m = 0; m < 2; m++)
		begin
			wb(1'b1, 4'h0, 4'hF, 32'(m) | 32'h0000_0004, '0);
			char_period(m ? 8 : 16);
			repeat (4)
			begin
				a = 17'($urandom);
				d = 8'($urandom);
				host(1'b1, a, d, '0);
				host(1'b1, a ^ 17'h0_0001, ~d, '0);
				host(1'b0, a, '0, d);
				host(1'b0, a ^ 17'h0_0001, '0, ~d);
			end
		end
		// Frame pulses drive both blink dividers
		for (int i = 1; i <= 30; i++)
		begin
			VSYNC <= 1'b1;
			repeat (3) @(posedge CLOCK);
			VSYNC <= 1'b0;
			repeat (3) @(posedge CLOCK);
			if (i == 15)
				check(32'(CURSOR_BLINK), 32'h0000_0001);
		end
		check(32'({CHAR_BLINK, CURSOR_BLINK}), 32'h0000_0002);
		finish_test;
	end
endmodule : test_video_memory_timing_arbiter

//--- test/vmta_dram_model.sv
module vmta_dram_model (
	// Clock
	input wire logic CLOCK,
	// Strobes and address
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic ROW_COL_SELECT,
	input wire logic BANK_SELECT_0,
	input wire logic BANK_SELECT_1,
	input wire logic [7:0] RAM_ADDR,
	// Data
	input wire logic [1:0] LANE_WE_N,
	input wire logic [15:0] RAM_DQ_OUT,
	output logic [15:0] RAM_DQ_IN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [logic [17:0]];
	logic [7:0] row = 8'h00;
	logic [15:0] last = 16'h0000;
	logic [17:0] key;
	// Cell from bank selects, latched row, live column
	assign key = {BANK_SELECT_1, BANK_SELECT_0, row, RAM_ADDR};
	// Whole word while column strobe low; floating bus shows no stale data
	always @*
	begin
		if (!CAS_N && ROW_COL_SELECT)
			RAM_DQ_IN = mem.exists(key) ? mem[key] : 16'h0000;
		else
			RAM_DQ_IN = ~last;
	end
	// Row latch and per-lane writes
	always @(posedge CLOCK)
	begin
		if (!RAS_N && !ROW_COL_SELECT)
			row <= RAM_ADDR;
		last <= RAM_DQ_IN;
		if (!CAS_N && ROW_COL_SELECT && LANE_WE_N != 2'b11)
		begin
			if (!mem.exists(key))
				mem[key] = 16'h0000;
			if (!LANE_WE_N[0])
				mem[key][7:0] = RAM_DQ_OUT[7:0];
			if (!LANE_WE_N[1])
				mem[key][15:8] = RAM_DQ_OUT[15:8];
		end
	end
endmodule : vmta_dram_model

//--- test/vmta_top_sva.sv
module vmta_top_sva (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Host channel
	input wire logic HOST_SEL,
	input wire logic HOST_WR,
	input wire logic [7:0] HOST_WDATA,
	input wire logic HOST_RDY,
	input wire logic GFX_MEM_SELECT_N,
	// Timing and memory
	input wire logic CHAR_CLK,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WORD_HALF_SELECT,
	input wire logic DISPLAY_CPU_SLOT,
	input wire logic GFX_WRITE_ENABLE_N,
	input wire logic [1:0] LANE_WE_N,
	input wire logic [15:0] RAM_DQ_OUT,
	input wire logic FIRST_WORD_STROBE,
	input wire logic SECOND_WORD_STROBE
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	logic prev_slot;
	logic slot_seen;
	// Slot kind at each row strobe, so alternation can be judged
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			prev_slot <= 1'b0;
			slot_seen <= 1'b0;
		end
		else if ($fell(RAS_N))
		begin
			prev_slot <= DISPLAY_CPU_SLOT;
			slot_seen <= 1'b1;
		end
	end
	AST_CAS_AFTER_RAS: assert property ($fell(RAS_N) |-> ##[1:2] $fell(CAS_N)) else $error("no column strobe");
	AST_SECOND_CAS: assert property ($rose(CAS_N) && !RAS_N |-> ##[1:2] $fell(CAS_N)) else $error("no second column");
	AST_HALF_FIRST: assert property ($fell(RAS_N) |-> !WORD_HALF_SELECT) else $error("half select wrong");
	AST_CHAR_PERIOD: assert property (CHAR_CLK |=> !CHAR_CLK [*7] ##[1:9] CHAR_CLK) else $error("char period");
	AST_WORDS: assert property (FIRST_WORD_STROBE |-> DISPLAY_CPU_SLOT ##[2:8] SECOND_WORD_STROBE)
		else $error("word strobes");
	AST_SLOT_ALT: assert property ($fell(RAS_N) && slot_seen |-> DISPLAY_CPU_SLOT != prev_slot)
		else $error("slots not alternating");
	AST_HOST_WAIT: assert property ($rose(HOST_SEL) |=> !GFX_MEM_SELECT_N && !HOST_RDY) else $error("no wait");
	// A request that just misses a raster slot end waits a wasted host slot, a raster slot and its own slot
	AST_HOST_ANSWER: assert property (HOST_SEL && !HOST_RDY |-> ##[1:48] HOST_RDY) else $error("no ready");
	AST_WRITE_LANE: assert property (!GFX_WRITE_ENABLE_N |-> HOST_WR && !DISPLAY_CPU_SLOT
		&& $countones(LANE_WE_N) == 1 && RAM_DQ_OUT == {2{HOST_WDATA}}) else $error("bad write");
	// Main scenarios reached
	cover property ($fell(RAS_N) && !DISPLAY_CPU_SLOT);
	cover property (!GFX_WRITE_ENABLE_N);
	cover property (SECOND_WORD_STROBE);
endmodule : vmta_top_sva
bind vmta_top vmta_top_sva i_sva (.*);
